/* rtl/driver_fault_status_flags.sv */
// Second fault status register: latched and live flags, converter actions
//
// What this block does
// - Buck B hot past filter time sets bit 23 and latches buck B off.
// - Clear of bit 23 succeeds only below hysteresis; then buck B may restart.
// - Bit 22 is live warning two for buck B, with hysteresis.
// - Bit 21 is live warning one for buck B, with hysteresis.
// - Bit 20 sets after two consecutive buck A cycles at maximum on-time.
// - Each max on-time event forces the buck off a while; flag stays latched.
// - In limp home, buck A max on-time flag auto-clears every restart period.
// - Bit 19 does the same for buck B, with the same forced-off interval, but has no limp home auto-clear.
// - Slow dimming clock sets bit 18 and selects the fallback clock.
// - External dimming clock returns only after clear with the clock healthy.
// - Bit 17 is live interface supply failure and forces limp home.
// - Bits 16 to 15 show watchdog progress, reset to 00.
// - Watchdog failure in active mode sets bit 14 and forces limp home.
// - Bit 11 is live buck B off-time below minimum.
// - Bit 10 is live buck A off-time at or above maximum.
// - Bit 9 is live buck B off-time at or above maximum.
// - Bit 8 reads 1 while the boost output is under its regulation level.
// - Bit 7 boost overvoltage uses set and clear filters; blocked by disable.
// - Bit 7 never newly sets while the boost feedback fault is present; a set bit stays until its clear filter.
// - Bit 0 is odd parity over the register.
`timescale 1ns/1ps
module driver_fault_status_flags
   import fault_status_pkg::*;
#(
   parameter int OVT_FILT_CYC = OVT_CYC,
   parameter int MAX_ON_OFF_CYC = TON_OFF_CYC,
   parameter int RESTART_CYC = AUTORESTART_CYC,
   parameter int OVP_SET_FILT_CYC = OVP_SET_CYC,
   parameter int OVP_CLR_FILT_CYC = OVP_CLR_CYC
) (
   input wire logic clk_sys, // Logic clock, 250 MHz
   input wire logic rst_n, // Async reset, active low
   input wire logic clk_en, // Freezes all state while low
   input wire sense_t sense, // Comparator levels from the pins
   input wire logic boost_disable, // Boost switched off by control
   input wire logic boost_feedback_fault, // Boost feedback pin fault
   input wire logic active_mode, // Device in active mode
   input wire logic watchdog_expired, // Watchdog timeout pulse
   input wire logic [1:0] watchdog_progress_in, // Watchdog timer fraction
   input wire logic rc_strobe, // Read-and-clear of this register
   output logic [REG_W-1:0] status, // Register contents with parity
   output drive_t drive // Converter actions
);
   localparam int OFF_W = $clog2(MAX_ON_OFF_CYC + 1);
   localparam int AR_W = $clog2(RESTART_CYC + 1);

   typedef struct packed {
      logic a_end_prev;
      logic b_end_prev;
      logic a_max_prev;
      logic b_max_prev;
      logic [OFF_W-1:0] a_off_cnt;
      logic [OFF_W-1:0] b_off_cnt;
      logic [AR_W-1:0] ar_cnt;
      logic ovt;
      logic tw_high;
      logic tw_low;
      logic a_max;
      logic b_max;
      logic clk_fail;
      logic watchdog_failure_flag;
      logic [REG_W-1:0] status;
      drive_t drive;
   } flag_state_t;

   flag_state_t cur_q;
   flag_state_t nxt_d;
   sense_t s;
   logic [$bits(sense_t)-1:0] s_raw;
   logic ovt_lvl;
   logic ovp_lvl;
   logic a_end;
   logic b_end;
   logic a_evt;
   logic b_evt;
   logic ar_tick;
   logic wd_evt;

   if (OVT_FILT_CYC < 1 || MAX_ON_OFF_CYC < 1
       || RESTART_CYC < 1) begin : g_chk
      $error("driver_fault_status_flags: counts must be at least 1");
   end

   // Sticky flag; a set in the clearing cycle wins
   function automatic logic latch(input logic q, input logic set,
                                  input logic clr);
      return set | (q & ~clr);
   endfunction : latch

   // Live flag with hysteresis band
   function automatic logic hyst(input logic q, input logic above,
                                 input logic below);
      return above | (q & ~below);
   endfunction : hyst

   level_sync #(
      .W($bits(sense_t))
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .din(sense),
      .dout(s_raw)
   );

   assign s = sense_t'(s_raw);

   fault_filter #(
      .SET_CYC(OVT_FILT_CYC),
      .CLR_CYC(1)
   ) u_ovt_filt (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .set_cond(s.b_temp_ge_tsd),
      .clr_cond(~s.b_temp_ge_tsd),
      .block(1'b0),
      .level(ovt_lvl)
   );

   // Filter blocks new sets only; a set flag still clears by its own filter
   fault_filter #(
      .SET_CYC(OVP_SET_FILT_CYC),
      .CLR_CYC(OVP_CLR_FILT_CYC)
   ) u_ovp_filt (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .set_cond(s.fb_above_on),
      .clr_cond(s.fb_below_off),
      .block(boost_disable | boost_feedback_fault),
      .level(ovp_lvl)
   );

   // Cycle ends come from the second sync flop, so edge detect is safe
   assign a_end = s.a_cycle_end & ~cur_q.a_end_prev;
   assign b_end = s.b_cycle_end & ~cur_q.b_end_prev;
   assign a_evt = a_end & s.a_at_max_on & cur_q.a_max_prev;
   assign b_evt = b_end & s.b_at_max_on & cur_q.b_max_prev;
   assign ar_tick = cur_q.drive.limp_home_mode
                    & (cur_q.ar_cnt == '0);
   assign wd_evt = watchdog_expired & active_mode;

   always_comb begin
      logic limp;
      logic [REG_W-1:0] w;
      limp = 1'b0;
      w = '0;
      nxt_d = cur_q;
      if (clk_en) begin
         nxt_d.a_end_prev = s.a_cycle_end;
         nxt_d.b_end_prev = s.b_cycle_end;
         // Pair of maximum cycles is consumed by the event it raises
         if (a_end) begin
            nxt_d.a_max_prev = s.a_at_max_on & ~cur_q.a_max_prev;
         end
         if (b_end) begin
            nxt_d.b_max_prev = s.b_at_max_on & ~cur_q.b_max_prev;
         end
         if (a_evt) begin
            nxt_d.a_off_cnt = OFF_W'(MAX_ON_OFF_CYC);
         end else if (cur_q.a_off_cnt != '0) begin
            nxt_d.a_off_cnt = cur_q.a_off_cnt - OFF_W'(1);
         end
         if (b_evt) begin
            nxt_d.b_off_cnt = OFF_W'(MAX_ON_OFF_CYC);
         end else if (cur_q.b_off_cnt != '0) begin
            nxt_d.b_off_cnt = cur_q.b_off_cnt - OFF_W'(1);
         end

         nxt_d.ovt = latch(cur_q.ovt, ovt_lvl,
                           rc_strobe & s.b_temp_below_tsd_hys);
         nxt_d.tw_high = hyst(cur_q.tw_high, s.b_temp_ge_tw2,
                              s.b_temp_below_tw2_hys);
         nxt_d.tw_low = hyst(cur_q.tw_low, s.b_temp_ge_tw1,
                             s.b_temp_below_tw1_hys);
         nxt_d.a_max = latch(cur_q.a_max, a_evt,
                             rc_strobe | ar_tick);
         nxt_d.b_max = latch(cur_q.b_max, b_evt, rc_strobe);
         nxt_d.clk_fail = latch(cur_q.clk_fail, s.dim_clk_slow,
                                rc_strobe & ~s.dim_clk_slow);
         nxt_d.watchdog_failure_flag = latch(cur_q.watchdog_failure_flag, wd_evt, rc_strobe);
         limp = s.iface_supply_low | nxt_d.watchdog_failure_flag;

         // Restart period runs only while in limp home
         if (!limp || ar_tick) begin
            nxt_d.ar_cnt = AR_W'(RESTART_CYC - 1);
         end else begin
            nxt_d.ar_cnt = cur_q.ar_cnt - AR_W'(1);
         end

         w[B_OVT] = nxt_d.ovt;
         w[B_TW_HIGH] = nxt_d.tw_high;
         w[B_TW_LOW] = nxt_d.tw_low;
         w[B_A_MAX_ON] = nxt_d.a_max;
         w[B_B_MAX_ON] = nxt_d.b_max;
         w[B_CLK_FAIL] = nxt_d.clk_fail;
         w[B_SUPPLY] = s.iface_supply_low;
         w[B_WD_PROG_HI:B_WD_PROG_LO] = watchdog_progress_in;
         w[B_WATCHDOG_FAILURE_FLAG] = nxt_d.watchdog_failure_flag;
         w[B_B_SHORT_OFF] = s.b_short_off;
         w[B_A_LONG_OFF] = s.a_long_off;
         w[B_B_LONG_OFF] = s.b_long_off;
         w[B_NOT_REG] = s.boost_below_target;
         w[B_OVP] = ovp_lvl;
         w[B_PARITY] = ~^w[REG_W-1:1];
         nxt_d.status = w;

         nxt_d.drive.buck_a_off = (nxt_d.a_off_cnt != '0);
         nxt_d.drive.buck_b_off = nxt_d.ovt
                                  | (nxt_d.b_off_cnt != '0);
         nxt_d.drive.fallback_dim_clk = nxt_d.clk_fail;
         nxt_d.drive.limp_home_mode = limp;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cur_q <= '0;
         cur_q.ar_cnt <= AR_W'(RESTART_CYC - 1);
         cur_q.status <= STATUS_RST;
      end else begin
         cur_q <= nxt_d;
      end
   end

   assign status = cur_q.status;
   assign drive = cur_q.drive;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   ovt_latch_off_a: assert property (
      clk_en && ovt_lvl |=> status[B_OVT] && drive.buck_b_off)
      else $error("over-temperature did not latch buck B off");

   ovt_clear_guard_a: assert property (
      clk_en && cur_q.ovt && !s.b_temp_below_tsd_hys |=> status[B_OVT])
      else $error("over-temperature cleared while still hot");

   warn_live_a: assert property (
      clk_en && s.b_temp_ge_tw2 && s.b_temp_ge_tw1
      |=> status[B_TW_HIGH] && status[B_TW_LOW])
      else $error("thermal warning not shown");

   max_on_pair_a: assert property (
      clk_en && a_end && s.a_at_max_on && cur_q.a_max_prev
      |=> status[B_A_MAX_ON] && drive.buck_a_off)
      else $error("buck A maximum on-time pair missed");

   max_on_window_a: assert property (
      clk_en && b_end && s.b_at_max_on && cur_q.b_max_prev
      |=> drive.buck_b_off && status[B_B_MAX_ON])
      else $error("buck B maximum on-time not acted on");

   single_max_a: assert property (
      clk_en && a_end && !cur_q.a_max_prev && !cur_q.a_max
      && !status[B_A_MAX_ON] |=> !status[B_A_MAX_ON])
      else $error("buck A flag set after one cycle");

   auto_restart_a: assert property (
      clk_en && ar_tick && !a_evt |=> !status[B_A_MAX_ON])
      else $error("limp home did not auto-clear buck A flag");

   clk_fallback_a: assert property (
      clk_en && s.dim_clk_slow
      |=> status[B_CLK_FAIL] && drive.fallback_dim_clk)
      else $error("fallback dimming clock not selected");

   clk_return_a: assert property (
      clk_en && !rc_strobe && cur_q.clk_fail |=> drive.fallback_dim_clk)
      else $error("external clock restored without clear");

   supply_limp_a: assert property (
      clk_en && s.iface_supply_low
      |=> status[B_SUPPLY] && drive.limp_home_mode)
      else $error("supply failure did not force limp home");

   watchdog_failure_flag_limp_a: assert property (
      clk_en && watchdog_expired && active_mode
      |=> status[B_WATCHDOG_FAILURE_FLAG] && drive.limp_home_mode)
      else $error("watchdog failure did not force limp home");

   wd_progress_a: assert property (
      clk_en |=> status[B_WD_PROG_HI:B_WD_PROG_LO]
                 == $past(watchdog_progress_in))
      else $error("watchdog progress field stale");

   ovp_block_a: assert property (
      clk_en && (boost_disable || boost_feedback_fault) && !ovp_lvl
      |=> !ovp_lvl)
      else $error("boost overvoltage set while blocked");

   odd_parity_a: assert property (
      ^status == 1'b1)
      else $error("register parity not odd");

   ovt_recover_c: cover property (
      cur_q.ovt ##1 !cur_q.ovt && !drive.buck_b_off);
   max_on_event_c: cover property (clk_en && a_evt ##1 drive.buck_a_off);
   limp_restart_c: cover property (clk_en && ar_tick && cur_q.a_max);
   clk_return_c: cover property (
      drive.fallback_dim_clk ##1 !drive.fallback_dim_clk);
endmodule : driver_fault_status_flags

/* rtl/fault_filter.sv */
// Set and clear time filter for one fault level
`timescale 1ns/1ps
module fault_filter #(
   parameter int SET_CYC = 1,
   parameter int CLR_CYC = 1
) (
   input wire logic clk_sys, // Logic clock
   input wire logic rst_n, // Async reset, active low
   input wire logic clk_en, // Freezes state while low
   input wire logic set_cond, // Condition that sets after SET_CYC
   input wire logic clr_cond, // Condition that clears after CLR_CYC
   input wire logic block, // Holds off any new set
   output logic level // Filtered fault level, from a flop
);
   typedef struct packed {
      logic [31:0] cnt;
      logic lvl;
   } filt_state_t;

   filt_state_t cur_q;
   filt_state_t nxt_d;

   if (SET_CYC < 1 || CLR_CYC < 1) begin : g_chk
      $error("fault_filter: filter counts must be at least 1");
   end

   always_comb begin
      nxt_d = cur_q;
      if (clk_en) begin
         if (!cur_q.lvl) begin
            if (set_cond && !block) begin
               if (cur_q.cnt == 32'(SET_CYC - 1)) begin
                  nxt_d.lvl = 1'b1;
                  nxt_d.cnt = '0;
               end else begin
                  nxt_d.cnt = cur_q.cnt + 32'h0000_0001;
               end
            end else begin
               nxt_d.cnt = '0;
            end
         end else begin
            if (clr_cond) begin
               if (cur_q.cnt == 32'(CLR_CYC - 1)) begin
                  nxt_d.lvl = 1'b0;
                  nxt_d.cnt = '0;
               end else begin
                  nxt_d.cnt = cur_q.cnt + 32'h0000_0001;
               end
            end else begin
               nxt_d.cnt = '0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cur_q <= '0;
      end else begin
         cur_q <= nxt_d;
      end
   end

   assign level = cur_q.lvl;
endmodule : fault_filter

/* rtl/fault_status_pkg.sv */
// Constants, field positions and carriers for the fault status flags
package fault_status_pkg;
   localparam int CLK_MHZ = 250;

   // Least time in ns to whole clock cycles, rounded up, never below one
   function automatic int min_cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction : min_cyc

   localparam int T_OVT_NS = 20000;
   localparam int T_TON_MAX_OFF_NS = 10000;
   localparam int T_AUTORESTART_NS = 1000000;
   localparam int T_BOOST_OVERVOLTAGE_FLAG_NS = 2000;
   localparam int T_BOOST_OVERVOLTAGE_FLAG_RST_NS = 2000;
   localparam int OVT_CYC = min_cyc(T_OVT_NS);
   localparam int TON_OFF_CYC = min_cyc(T_TON_MAX_OFF_NS);
   localparam int AUTORESTART_CYC = min_cyc(T_AUTORESTART_NS);
   localparam int OVP_SET_CYC = min_cyc(T_BOOST_OVERVOLTAGE_FLAG_NS);
   localparam int OVP_CLR_CYC = min_cyc(T_BOOST_OVERVOLTAGE_FLAG_RST_NS);

   localparam int REG_W = 24;
   localparam int B_OVT = 23;
   localparam int B_TW_HIGH = 22;
   localparam int B_TW_LOW = 21;
   localparam int B_A_MAX_ON = 20;
   localparam int B_B_MAX_ON = 19;
   localparam int B_CLK_FAIL = 18;
   localparam int B_SUPPLY = 17;
   localparam int B_WD_PROG_HI = 16;
   localparam int B_WD_PROG_LO = 15;
   localparam int B_WATCHDOG_FAILURE_FLAG = 14;
   localparam int B_B_SHORT_OFF = 11;
   localparam int B_A_LONG_OFF = 10;
   localparam int B_B_LONG_OFF = 9;
   localparam int B_NOT_REG = 8;
   localparam int B_OVP = 7;
   localparam int B_PARITY = 0;
   // All flags clear, odd parity bit set
   localparam logic [23:0] STATUS_RST = 24'h00_0001;
   localparam logic [1:0] WD_PROG_RST = 2'h0;

   // Comparator and monitor levels arriving from outside the logic clock
   typedef struct packed {
      logic b_temp_ge_tsd;
      logic b_temp_below_tsd_hys;
      logic b_temp_ge_tw2;
      logic b_temp_below_tw2_hys;
      logic b_temp_ge_tw1;
      logic b_temp_below_tw1_hys;
      logic a_cycle_end;
      logic a_at_max_on;
      logic b_cycle_end;
      logic b_at_max_on;
      logic dim_clk_slow;
      logic iface_supply_low;
      logic b_short_off;
      logic a_long_off;
      logic b_long_off;
      logic boost_below_target;
      logic fb_above_on;
      logic fb_below_off;
   } sense_t;

   // Actions on the converters
   typedef struct packed {
      logic buck_a_off;
      logic buck_b_off;
      logic fallback_dim_clk;
      logic limp_home_mode;
   } drive_t;
endpackage : fault_status_pkg

/* rtl/level_sync.sv */
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module level_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys, // Logic clock
   input wire logic rst_n, // Async reset, active low
   input wire logic clk_en, // Freezes state while low
   input wire logic [W-1:0] din, // Asynchronous levels
   output logic [W-1:0] dout // Synchronised levels
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] safe;
   } sync_state_t;

   sync_state_t cur_q;
   sync_state_t nxt_d;

   if (W < 1) begin : g_chk
      $error("level_sync: W must be at least 1");
   end

   always_comb begin
      nxt_d = cur_q;
      if (clk_en) begin
         nxt_d.meta = din;
         nxt_d.safe = cur_q.meta;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cur_q <= '0;
      end else begin
         cur_q <= nxt_d;
      end
   end

   assign dout = cur_q.safe;
endmodule : level_sync

/* sim/driver_fault_status_flags_tb_top.sv */
// Self-checking bench for the second fault status register
`timescale 1ns/1ps
module driver_fault_status_flags_tb_top;
   import fault_status_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   sense_t sense;
   sense_t cold;
   logic boost_disable = 1'b0;
   logic boost_feedback_fault = 1'b0;
   logic active_mode = 1'b0;
   logic watchdog_expired = 1'b0;
   logic [1:0] watchdog_progress_in = 2'h0;
   logic rc_strobe;
   logic [REG_W-1:0] status;
   logic [REG_W-1:0] last_read;
   drive_t drive;
   drive_t dr_mid;
   logic [23:0] st_mid;
   int fails = 0;
   int n_tests = 0;
   int cyc_n = 0;

   always #2 clk_sys = ~clk_sys;

   driver_fault_status_flags #(.OVT_FILT_CYC(4), .MAX_ON_OFF_CYC(5),
      .RESTART_CYC(20), .OVP_SET_FILT_CYC(3), .OVP_CLR_FILT_CYC(3)) u_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .sense(sense),
      .boost_disable(boost_disable),
      .boost_feedback_fault(boost_feedback_fault),
      .active_mode(active_mode), .watchdog_expired(watchdog_expired),
      .watchdog_progress_in(watchdog_progress_in), .rc_strobe(rc_strobe),
      .status(status), .drive(drive));

   host_model u_host (.clk_sys(clk_sys), .status(status),
      .rc_strobe(rc_strobe), .last_read(last_read));

   function automatic logic [23:0] img(input logic [23:0] v);
      return {v[23:1], ~^v[23:1]};
   endfunction : img

   function automatic logic [23:0] bit_of(input int k);
      return 24'h00_0001 << k;
   endfunction : bit_of

   task automatic chk_st(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== img(exp)) begin
         fails++;
         $display("MISMATCH t=%0t status %h exp %h", $time, got, img(exp));
      end
   endtask : chk_st

   task automatic chk_dr(input drive_t got, input drive_t exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t drive %h exp %h", $time, got, exp);
      end
   endtask : chk_dr

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : step

   task automatic drv(input sense_t s, input int n);
      @(posedge clk_sys);
      sense <= s;
      step(n);
   endtask : drv

   // Band leaves the level inside the hysteresis, where the flag must hold
   task automatic live_case(input sense_t flip, input sense_t band,
                            input int k, input logic lim);
      drv(cold ^ flip, 5);
      chk_st(status, bit_of(k));
      chk_dr(drive, lim ? 4'h1 : 4'h0);
      drv(cold ^ band, 5);
      chk_st(status, (band != '0) ? bit_of(k) : 24'h00_0000);
      drv(cold, 5);
      chk_st(status, 24'h00_0000);
   endtask : live_case

   // One switching cycle end; b is the cycle-end bit, b-1 its max-on level
   task automatic cyc(input int b, input logic mx);
      @(posedge clk_sys);
      sense[b-1] <= mx;
      step(3);
      @(posedge clk_sys);
      sense[b] <= 1'b1;
      step(4);
      st_mid = status;
      dr_mid = drive;
      @(posedge clk_sys);
      sense[b] <= 1'b0;
      step(4);
   endtask : cyc

   task automatic summarize();
      $display("Checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize

   always @(posedge clk_sys) begin
      cyc_n++;
      if (cyc_n == 4000) begin
         fails++;
         $display("MISMATCH t=%0t run did not finish", $time);
         summarize();
      end
   end

   initial begin
      // Cold die, feedback low: all hysteresis comparators report below
      cold = 18'h1_5001;
      sense = cold;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      step(1);
      chk_st(status, 24'h00_0000);
      chk_dr(drive, 4'h0);
      live_case(18'h0_c000, 18'h0_4000, B_TW_HIGH, 1'b0);
      live_case(18'h0_3000, 18'h0_1000, B_TW_LOW, 1'b0);
      live_case(18'h0_0040, 18'h0_0000, B_SUPPLY, 1'b1);
      live_case(18'h0_0020, 18'h0_0000, B_B_SHORT_OFF, 1'b0);
      live_case(18'h0_0010, 18'h0_0000, B_A_LONG_OFF, 1'b0);
      live_case(18'h0_0008, 18'h0_0000, B_B_LONG_OFF, 1'b0);
      live_case(18'h0_0004, 18'h0_0000, B_NOT_REG, 1'b0);
      // Watchdog progress and failure
      @(posedge clk_sys);
      watchdog_progress_in <= 2'h2;
      step(2);
      chk_st(status, bit_of(B_WD_PROG_HI));
      @(posedge clk_sys);
      watchdog_progress_in <= 2'h0;
      watchdog_expired <= 1'b1;
      @(posedge clk_sys);
      watchdog_expired <= 1'b0;
      step(2);
      chk_st(status, 24'h00_0000);
      @(posedge clk_sys);
      watchdog_expired <= 1'b1;
      active_mode <= 1'b1;
      @(posedge clk_sys);
      watchdog_expired <= 1'b0;
      step(1);
      chk_st(status, bit_of(B_WATCHDOG_FAILURE_FLAG));
      chk_dr(drive, 4'h1);
      u_host.read_clear();
      step(1);
      chk_st(last_read, bit_of(B_WATCHDOG_FAILURE_FLAG));
      chk_st(status, 24'h00_0000);
      chk_dr(drive, 4'h0);
      // Dimming clock failure, clear refused while still slow
      drv(cold ^ 18'h0_0080, 5);
      chk_st(status, bit_of(B_CLK_FAIL));
      chk_dr(drive, 4'h2);
      u_host.read_clear();
      step(1);
      chk_st(status, bit_of(B_CLK_FAIL));
      drv(cold, 5);
      chk_dr(drive, 4'h2);
      u_host.read_clear();
      step(1);
      chk_st(status, 24'h00_0000);
      chk_dr(drive, 4'h0);
      // Over-temperature: short burst filtered, then latched off
      @(posedge clk_sys);
      sense <= cold ^ 18'h3_0000;
      @(posedge clk_sys);
      sense <= cold;
      step(8);
      chk_st(status, 24'h00_0000);
      drv(cold ^ 18'h3_0000, 10);
      chk_st(status, bit_of(B_OVT));
      chk_dr(drive, 4'h4);
      drv(cold ^ 18'h1_0000, 5);
      u_host.read_clear();
      step(1);
      chk_st(status, bit_of(B_OVT));
      chk_dr(drive, 4'h4);
      drv(cold, 5);
      u_host.read_clear();
      step(1);
      chk_st(status, 24'h00_0000);
      chk_dr(drive, 4'h0);
      // Maximum on-time, buck A then buck B; a normal cycle breaks a pair
      for (int k = 0; k < 2; k++) begin
         cyc(k ? 9 : 11, 1'b1);
         cyc(k ? 9 : 11, 1'b0);
         cyc(k ? 9 : 11, 1'b1);
         chk_st(status, 24'h00_0000);
         cyc(k ? 9 : 11, 1'b1);
         chk_st(st_mid, bit_of(k ? B_B_MAX_ON : B_A_MAX_ON));
         chk_dr(dr_mid, k ? 4'h4 : 4'h8);
         cyc(k ? 9 : 11, 1'b0);
         step(40);
         chk_st(status, bit_of(k ? B_B_MAX_ON : B_A_MAX_ON));
         chk_dr(drive, 4'h0);
         u_host.read_clear();
         step(1);
         chk_st(status, 24'h00_0000);
      end
      // Limp home clears the buck A flag on its own
      drv(cold ^ 18'h0_0040, 5);
      cyc(11, 1'b1);
      cyc(11, 1'b1);
      chk_st(st_mid, bit_of(B_A_MAX_ON) | bit_of(B_SUPPLY));
      cyc(11, 1'b0);
      step(25);
      chk_st(status, bit_of(B_SUPPLY));
      drv(cold, 5);
      // Boost overvoltage held off by disable and by feedback fault
      @(posedge clk_sys);
      boost_disable <= 1'b1;
      drv(cold ^ 18'h0_0003, 10);
      chk_st(status, 24'h00_0000);
      @(posedge clk_sys);
      boost_disable <= 1'b0;
      boost_feedback_fault <= 1'b1;
      step(10);
      chk_st(status, 24'h00_0000);
      @(posedge clk_sys);
      boost_feedback_fault <= 1'b0;
      step(10);
      chk_st(status, bit_of(B_OVP));
      drv(cold, 10);
      chk_st(status, 24'h00_0000);
      // Low clock enable freezes syncs and flags; the slow clock shows late
      @(posedge clk_sys);
      clk_en <= 1'b0;
      drv(cold ^ 18'h0_0080, 5);
      chk_st(status, 24'h00_0000);
      chk_dr(drive, 4'h0);
      @(posedge clk_sys);
      clk_en <= 1'b1;
      step(4);
      chk_st(status, bit_of(B_CLK_FAIL));
      chk_dr(drive, 4'h2);
      drv(cold, 5);
      u_host.read_clear();
      step(1);
      chk_st(status, 24'h00_0000);
      chk_dr(drive, 4'h0);
      summarize();
   end
endmodule : driver_fault_status_flags_tb_top

/* sim/host_model.sv */
// Host side of the serial link: read-and-clear of the status register
`timescale 1ns/1ps
module host_model
   import fault_status_pkg::*;
(
   input wire logic clk_sys, // Logic clock
   input wire logic [REG_W-1:0] status, // Register image from the device
   output logic rc_strobe, // One-cycle read-and-clear pulse
   output logic [REG_W-1:0] last_read // Image taken along with the clear
);
   initial rc_strobe = 1'b0;
   initial last_read = '0;

   // Meant for use once the cause has gone; a clear while it persists
   // only sees the flag stay set, refusal tests do it on purpose
   task automatic read_clear();
      @(posedge clk_sys);
      rc_strobe <= 1'b1;
      @(posedge clk_sys);
      last_read <= status;
      rc_strobe <= 1'b0;
   endtask : read_clear
endmodule : host_model
